// ---- rotate_subtract_skip_execute_unit_tb.sv ----
// Purpose: Self-checking bench for the rotate, subtract and skip execute unit
// Assumes: Ops and register accesses driven by NBA at rising edges, outputs sampled 1 ns later
// Notes: Expected values come from hand figures and a local subtract reference
`default_nettype none

module rotate_subtract_skip_execute_unit_tb
  import rssk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rst, op_valid, reg_wr, reg_rd, mem_we, skip_req;
  logic c_fl, ac_fl, z_fl, ov_fl;
  logic [4:0] op_code;
  logic [7:0] mem_data, imm, reg_wdata, reg_rdata, acc, mem_wdata;
  logic [2:0] bit_sel;
  logic [1:0] reg_addr;
  logic [3:0] flags;
  int failures = 0;
  int samples_checked = 0;

  // Flags packed as in the flags register: ov, z, ac, c
  assign flags = {ov_fl, z_fl, ac_fl, c_fl};

  rssk_exec_unit dut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_op_valid(op_valid), .i_op_code(op_code),
    .i_mem_data(mem_data), .i_imm(imm), .i_bit_sel(bit_sel), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .o_acc(acc), .o_carry_flag(c_fl), .o_half_byte_borrow_flag(ac_fl), .o_zero_flag(z_fl),
    .o_signed_wrap_flag(ov_fl), .o_mem_we(mem_we), .o_mem_wdata(mem_wdata),
    .o_skip_req(skip_req)
  );

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : reg_read

  task automatic prep(input logic [7:0] a, input logic [3:0] f);
    reg_write(REG_ACC_IDX, a);
    reg_write(REG_FLAGS_IDX, {4'h0, f});
  endtask : prep

  // Issue one op; with dummy set, a flag-and-memory-changing op is offered in the skip slot
  task automatic run_op(input rssk_op_e op, input logic [7:0] m, input logic [7:0] im,
                        input logic [2:0] bs, input logic [7:0] e_acc, input logic [3:0] e_fl,
                        input logic e_we, input logic [7:0] e_wd, input logic e_skip,
                        input bit dummy);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    mem_data <= m;
    imm <= im;
    bit_sel <= bs;
    @(posedge ref_clk);
    if (dummy)
    begin
      op_code <= op_minus_with_borrow_to_mem;
      mem_data <= 8'h01;
    end
    else
      op_valid <= 1'b0;
    #1 chk(acc, e_acc);
    chk({4'h0, flags}, {4'h0, e_fl});
    chk({7'h00, mem_we}, {7'h00, e_we});
    chk({7'h00, skip_req}, {7'h00, e_skip});
    if (e_we)
      chk(mem_wdata, e_wd);
  endtask : run_op

  // The op offered in the skip slot must leave no trace
  task automatic dummy_chk(input logic [7:0] e_acc, input logic [3:0] e_fl);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1 chk(acc, e_acc);
    chk({4'h0, flags}, {4'h0, e_fl});
    chk({6'h00, mem_we, skip_req}, 8'h00);
  endtask : dummy_chk

  // Independent subtract reference: {ov, z, ac, c, diff}, carry high means no borrow
  function automatic logic [11:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] f;
    logic [4:0] h;
    f = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
    sub_ref = {(a[7] ^ b[7]) & (f[7] ^ a[7]), f[7:0] == 8'h00, ~h[4], ~f[8], f[7:0]};
  endfunction : sub_ref

  task automatic registers();
    reg_read(REG_ACC_IDX, ACC_RST);
    reg_read(REG_FLAGS_IDX, 8'h00);
    reg_write(REG_ACC_IDX, 8'h5a);
    reg_write(REG_FLAGS_IDX, 8'hff);
    reg_write(2'h2, 8'h77);
    reg_read(REG_ACC_IDX, 8'h5a);
    reg_read(REG_FLAGS_IDX, 8'h0f);
    reg_read(2'h3, 8'h00);
    reg_read(2'h2, 8'h00);
  endtask : registers

  task automatic rotates();
    prep(8'h3c, 4'hf);
    run_op(op_rotate_left_to_accum, 8'h96, 8'h00, 3'h0, 8'h2d, 4'hf, 0, 8'h00, 0, 0);
    reg_write(REG_FLAGS_IDX, 8'h0e);
    run_op(op_rotate_left_thru_flag_in_mem, 8'h96, 8'h00, 3'h0, 8'h2d, 4'hf, 1, 8'h2c, 0, 0);
    run_op(op_rotate_left_thru_flag_to_accum, 8'h16, 8'h00, 3'h0, 8'h2d, 4'he, 0, 8'h00, 0, 0);
    run_op(op_rotate_right_in_mem, 8'h96, 8'h00, 3'h0, 8'h2d, 4'he, 1, 8'h4b, 0, 0);
    run_op(op_rotate_right_to_accum, 8'h97, 8'h00, 3'h0, 8'hcb, 4'he, 0, 8'h00, 0, 0);
    run_op(op_rotate_right_thru_flag_in_mem, 8'h97, 8'h00, 3'h0, 8'hcb, 4'hf, 1, 8'h4b, 0, 0);
    run_op(op_rotate_right_thru_flag_to_accum, 8'h96, 8'h00, 3'h0, 8'hcb, 4'he, 0, 8'h00, 0, 0);
  endtask : rotates

  // Other flags preset to the inverse of their result so a missed update shows
  task automatic sub_case(input rssk_op_e op, input logic [7:0] a, input logic [7:0] b,
                          input logic cin);
    logic [11:0] r;
    logic to_mem;
    logic use_imm;
    logic borrow_op;
    borrow_op = (op == op_minus_with_borrow_to_accum) || (op == op_minus_with_borrow_to_mem);
    to_mem = (op == op_minus_with_borrow_to_mem) || (op == op_minus_result_in_mem);
    use_imm = (op == op_minus_imm_to_accum);
    r = sub_ref(a, b, borrow_op ? cin : 1'b1);
    prep(a, {~r[11:9], cin});
    run_op(op, use_imm ? ~b : b, use_imm ? b : ~b, 3'h0, to_mem ? a : r[7:0], r[11:8],
           to_mem, r[7:0], 0, 0);
  endtask : sub_case

  task automatic subtracts();
    rssk_op_e ops [5] = '{op_minus_with_borrow_to_accum, op_minus_with_borrow_to_mem,
                          op_minus_mem_to_accum, op_minus_result_in_mem, op_minus_imm_to_accum};
    logic [7:0] pa [5] = '{8'h05, 8'h80, 8'h10, 8'h07, 8'h7f};
    logic [7:0] pb [5] = '{8'h07, 8'h01, 8'h01, 8'h07, 8'hff};
    for (int o = 0; o < 5; o++)
      for (int p = 0; p < 5; p++)
        for (int c = 0; c < 2; c++)
          sub_case(ops[o], pa[p], pb[p], c[0]);
  endtask : subtracts

  task automatic skips();
    prep(8'h33, 4'ha);
    run_op(op_dec_skip_on_zero, 8'h01, 8'h00, 3'h0, 8'h33, 4'ha, 1, 8'h00, 1, 1);
    dummy_chk(8'h33, 4'ha);
    run_op(op_dec_skip_on_zero, 8'h02, 8'h00, 3'h0, 8'h33, 4'ha, 1, 8'h01, 0, 0);
    run_op(op_dec_skip_on_zero_to_accum, 8'h01, 8'h00, 3'h0, 8'h00, 4'ha, 0, 8'h00, 1, 1);
    dummy_chk(8'h00, 4'ha);
    run_op(op_inc_skip_on_zero, 8'hff, 8'h00, 3'h0, 8'h00, 4'ha, 1, 8'h00, 1, 1);
    dummy_chk(8'h00, 4'ha);
    run_op(op_inc_skip_on_zero, 8'hfe, 8'h00, 3'h0, 8'h00, 4'ha, 1, 8'hff, 0, 0);
    run_op(op_inc_skip_on_zero_to_accum, 8'hff, 8'h00, 3'h0, 8'h00, 4'ha, 0, 8'h00, 1, 1);
    dummy_chk(8'h00, 4'ha);
    run_op(op_inc_skip_on_zero_to_accum, 8'h41, 8'h00, 3'h0, 8'h42, 4'ha, 0, 8'h00, 0, 0);
    run_op(op_skip_if_bit_one, 8'h10, 8'h00, 3'h4, 8'h42, 4'ha, 0, 8'h00, 1, 1);
    dummy_chk(8'h42, 4'ha);
    run_op(op_skip_if_bit_one, 8'hef, 8'h00, 3'h4, 8'h42, 4'ha, 0, 8'h00, 0, 0);
    run_op(op_skip_if_mem_zero, 8'h00, 8'h00, 3'h0, 8'h42, 4'ha, 0, 8'h00, 1, 1);
    dummy_chk(8'h42, 4'ha);
    run_op(op_skip_if_mem_zero, 8'h80, 8'h00, 3'h0, 8'h42, 4'ha, 0, 8'h00, 0, 0);
    run_op(op_skip_if_zero_load_accum, 8'h00, 8'h00, 3'h0, 8'h00, 4'ha, 0, 8'h00, 1, 1);
    dummy_chk(8'h00, 4'ha);
    run_op(op_skip_if_zero_load_accum, 8'h5a, 8'h00, 3'h0, 8'h5a, 4'ha, 0, 8'h00, 0, 0);
  endtask : skips

  task automatic set_swap();
    prep(8'h21, 4'h5);
    run_op(op_set_byte_in_mem, 8'h00, 8'h00, 3'h0, 8'h21, 4'h5, 1, BYTE_ALL_ONES, 0, 0);
    run_op(op_set_bit_in_mem, 8'h00, 8'h00, 3'h7, 8'h21, 4'h5, 1, 8'h80, 0, 0);
    run_op(op_set_bit_in_mem, 8'h5a, 8'h00, 3'h0, 8'h21, 4'h5, 1, 8'h5b, 0, 0);
    run_op(op_nibble_exchange_in_mem, 8'h3c, 8'h00, 3'h0, 8'h21, 4'h5, 1, 8'hc3, 0, 0);
    run_op(op_nibble_exchange_to_accum, 8'ha5, 8'h00, 3'h0, 8'h5a, 4'h5, 0, 8'h00, 0, 0);
    run_op(op_nop, 8'h00, 8'h00, 3'h0, 8'h5a, 4'h5, 0, 8'h00, 0, 0);
    // An undecoded code must behave as a no-op even with a zero operand
    run_op(rssk_op_e'(5'h1f), 8'h00, 8'h00, 3'h0, 8'h5a, 4'h5, 0, 8'h00, 0, 0);
  endtask : set_swap

  // A second reset in mid-run must clear state at once
  task automatic mid_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    #1 chk(acc, ACC_RST);
    chk({4'h0, flags}, {4'h0, FLAGS_RST});
    chk({6'h00, mem_we, skip_req}, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
  endtask : mid_reset

  // Main sequence
  initial
  begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = 5'h00;
    mem_data = 8'h00;
    imm = 8'h00;
    bit_sel = 3'h0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    registers();
    rotates();
    subtracts();
    skips();
    set_swap();
    mid_reset();
    registers();
    wrap_up();
  end

  // Hang guard: the whole run needs far fewer cycles than this
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

endmodule : rotate_subtract_skip_execute_unit_tb

`default_nettype wire

// ---- rssk_exec_unit.sv ----
// Purpose: Execute datapath for rotate, subtract, skip, set and swap operations
// Assumes: Decode presents operand byte, immediate and bit index with a valid strobe
// Notes: Results land one edge after issue; skip suppresses the following slot
//
// Notes on behaviour
// - Rotate left to accumulator: top bit wraps to bit 0, no flag changes.
// - Rotate left through carry in memory: old carry to bit 0, bit 7 to carry.
// - Same nine-bit left rotation, result to accumulator, memory untouched.
// - Rotate right in memory: bit 0 wraps to bit 7, flags untouched.
// - Rotate right to accumulator with wrap, memory and flags untouched.
// - Rotate right through carry in memory: carry to bit 7, bit 0 to carry.
// - Same nine-bit right rotation into accumulator, memory untouched.
// - Accumulator minus operand minus inverted carry into accumulator, four flags.
// - Same borrow subtract, result written back to memory, four flags.
// - Accumulator minus operand into accumulator; carry low means negative.
// - Accumulator minus operand into memory; carry and three other flags.
// - Accumulator minus immediate into accumulator; carry high means no borrow.
// - Decrement memory, write back, skip next slot when result is zero.
// - Operand minus one into accumulator, skip when zero, memory untouched.
// - Increment memory, write back, skip next slot on wrap to zero.
// - Operand plus one into accumulator, skip when zero, memory untouched.
// - Skip when selected memory bit is one; flags untouched.
// - Skip with dummy slot when whole memory byte is zero.
// - Set writes all ones or one selected bit; no flags change.
// - Nibble swap to memory or accumulator; no flags change.
// - Copy memory byte to accumulator, skip when it is zero.
//
// Our own choices: strobed register access and the address map.
`default_nettype none

module rssk_exec_unit
  import rssk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire logic [4:0] i_op_code,
  input wire logic [DATA_W-1:0] i_mem_data,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic [2:0] i_bit_sel,
  input wire logic [1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic [DATA_W-1:0] o_acc,
  output logic o_carry_flag,
  output logic o_half_byte_borrow_flag,
  output logic o_zero_flag,
  output logic o_signed_wrap_flag,
  output logic o_mem_we,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic o_skip_req
);

  rssk_state_e state_r;
  rssk_op_e op;
  logic exec;
  logic [DATA_W-1:0] acc_r;
  logic c_r;
  logic ac_r;
  logic z_r;
  logic ov_r;
  logic [DATA_W-1:0] res_nxt;
  logic wr_acc;
  logic wr_mem;
  logic skip_nxt;
  logic c_nxt;
  logic ac_nxt;
  logic z_nxt;
  logic ov_nxt;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] sub_b;
  logic sub_bin;
  logic [DATA_W-1:0] sub_diff;
  logic sub_c;
  logic sub_ac;
  logic sub_z;
  logic sub_ov;
  logic [DATA_W-1:0] dec_val;
  logic [DATA_W-1:0] inc_val;
  logic [FLAGS_W-1:0] flags_pack;

  // An issue in the dummy slot is the skipped instruction and is dropped
  assign op = rssk_op_e'(i_op_code);
  assign exec = i_op_valid && (state_r == st_run);
  assign bit_mask = BYTE_ONE << i_bit_sel;
  assign dec_val = i_mem_data - BYTE_ONE;
  assign inc_val = i_mem_data + BYTE_ONE;

  // Subtractor operand selection; borrow only for the borrow forms
  assign sub_b = (op == op_minus_imm_to_accum) ? i_imm : i_mem_data;
  assign sub_bin = ((op == op_minus_with_borrow_to_accum)
                 || (op == op_minus_with_borrow_to_mem)) & ~c_r;

  rssk_sub_unit u_sub (
    .i_minuend(acc_r),
    .i_subtrahend(sub_b),
    .i_borrow_in(sub_bin),
    .o_diff(sub_diff),
    .o_carry(sub_c),
    .o_half(sub_ac),
    .o_zero(sub_z),
    .o_wrap(sub_ov)
  );

  // Result, destination, skip and flag selection per operation
  always_comb
  begin
    res_nxt = BYTE_ZERO;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    skip_nxt = 1'b0;
    c_nxt = c_r;
    ac_nxt = ac_r;
    z_nxt = z_r;
    ov_nxt = ov_r;
    case (op)
      op_rotate_left_to_accum:
      begin
        res_nxt = {i_mem_data[MSB_POS-1:0], i_mem_data[MSB_POS]};
        wr_acc = 1'b1;
      end
      op_rotate_left_thru_flag_in_mem:
      begin
        res_nxt = {i_mem_data[MSB_POS-1:0], c_r};
        c_nxt = i_mem_data[MSB_POS];
        wr_mem = 1'b1;
      end
      op_rotate_left_thru_flag_to_accum:
      begin
        res_nxt = {i_mem_data[MSB_POS-1:0], c_r};
        c_nxt = i_mem_data[MSB_POS];
        wr_acc = 1'b1;
      end
      op_rotate_right_in_mem:
      begin
        res_nxt = {i_mem_data[0], i_mem_data[MSB_POS:1]};
        wr_mem = 1'b1;
      end
      op_rotate_right_to_accum:
      begin
        res_nxt = {i_mem_data[0], i_mem_data[MSB_POS:1]};
        wr_acc = 1'b1;
      end
      op_rotate_right_thru_flag_in_mem:
      begin
        res_nxt = {c_r, i_mem_data[MSB_POS:1]};
        c_nxt = i_mem_data[0];
        wr_mem = 1'b1;
      end
      op_rotate_right_thru_flag_to_accum:
      begin
        res_nxt = {c_r, i_mem_data[MSB_POS:1]};
        c_nxt = i_mem_data[0];
        wr_acc = 1'b1;
      end
      op_minus_with_borrow_to_accum, op_minus_mem_to_accum, op_minus_imm_to_accum:
      begin
        res_nxt = sub_diff;
        wr_acc = 1'b1;
        c_nxt = sub_c;
        ac_nxt = sub_ac;
        z_nxt = sub_z;
        ov_nxt = sub_ov;
      end
      op_minus_with_borrow_to_mem, op_minus_result_in_mem:
      begin
        res_nxt = sub_diff;
        wr_mem = 1'b1;
        c_nxt = sub_c;
        ac_nxt = sub_ac;
        z_nxt = sub_z;
        ov_nxt = sub_ov;
      end
      op_dec_skip_on_zero:
      begin
        res_nxt = dec_val;
        wr_mem = 1'b1;
        skip_nxt = (dec_val == BYTE_ZERO);
      end
      op_dec_skip_on_zero_to_accum:
      begin
        res_nxt = dec_val;
        wr_acc = 1'b1;
        skip_nxt = (dec_val == BYTE_ZERO);
      end
      op_inc_skip_on_zero:
      begin
        res_nxt = inc_val;
        wr_mem = 1'b1;
        skip_nxt = (inc_val == BYTE_ZERO);
      end
      op_inc_skip_on_zero_to_accum:
      begin
        res_nxt = inc_val;
        wr_acc = 1'b1;
        skip_nxt = (inc_val == BYTE_ZERO);
      end
      op_skip_if_bit_one:
      begin
        skip_nxt = ((i_mem_data & bit_mask) != BYTE_ZERO);
      end
      op_skip_if_mem_zero:
      begin
        skip_nxt = (i_mem_data == BYTE_ZERO);
      end
      op_skip_if_zero_load_accum:
      begin
        res_nxt = i_mem_data;
        wr_acc = 1'b1;
        skip_nxt = (i_mem_data == BYTE_ZERO);
      end
      op_set_byte_in_mem:
      begin
        res_nxt = BYTE_ALL_ONES;
        wr_mem = 1'b1;
      end
      op_set_bit_in_mem:
      begin
        res_nxt = i_mem_data | bit_mask;
        wr_mem = 1'b1;
      end
      op_nibble_exchange_in_mem:
      begin
        res_nxt = {i_mem_data[NIB_W-1:0], i_mem_data[MSB_POS:NIB_W]};
        wr_mem = 1'b1;
      end
      op_nibble_exchange_to_accum:
      begin
        res_nxt = {i_mem_data[NIB_W-1:0], i_mem_data[MSB_POS:NIB_W]};
        wr_acc = 1'b1;
      end
      default:
      begin
        res_nxt = BYTE_ZERO;
      end
    endcase
  end

  // Sequencer: a taken skip spends exactly one dummy slot
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      state_r <= st_run;
    else
      case (state_r)
        st_run:
          if (exec && skip_nxt)
            state_r <= st_dummy;
        st_dummy:
          state_r <= st_run;
        default:
          state_r <= st_run;
      endcase
  end

  // Accumulator; execution wins over a software write in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      acc_r <= ACC_RST;
    else if (exec && wr_acc)
      acc_r <= res_nxt;
    else if (i_reg_wr && (i_reg_addr == REG_ACC_IDX))
      acc_r <= i_reg_wdata;
  end

  // Flags; only the fields an operation names are changed
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      c_r <= FLAGS_RST[FLAG_C_POS];
      ac_r <= FLAGS_RST[FLAG_AC_POS];
      z_r <= FLAGS_RST[FLAG_Z_POS];
      ov_r <= FLAGS_RST[FLAG_OV_POS];
    end
    else if (exec)
    begin
      c_r <= c_nxt;
      ac_r <= ac_nxt;
      z_r <= z_nxt;
      ov_r <= ov_nxt;
    end
    else if (i_reg_wr && (i_reg_addr == REG_FLAGS_IDX))
    begin
      c_r <= i_reg_wdata[FLAG_C_POS];
      ac_r <= i_reg_wdata[FLAG_AC_POS];
      z_r <= i_reg_wdata[FLAG_Z_POS];
      ov_r <= i_reg_wdata[FLAG_OV_POS];
    end
  end

  // Memory write-back port, one pulse per writing operation
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= BYTE_ZERO;
    end
    else
    begin
      o_mem_we <= exec && wr_mem;
      if (exec && wr_mem)
        o_mem_wdata <= res_nxt;
    end
  end

  // Skip request to fetch, one pulse
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_skip_req <= 1'b0;
    else
      o_skip_req <= exec && skip_nxt;
  end

  // Register read data, valid the cycle after the read strobe
  assign flags_pack = {ov_r, z_r, ac_r, c_r};
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= BYTE_ZERO;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == REG_ACC_IDX)
        o_reg_rdata <= acc_r;
      else if (i_reg_addr == REG_FLAGS_IDX)
        o_reg_rdata <= {{(DATA_W-FLAGS_W){1'b0}}, flags_pack};
      else
        o_reg_rdata <= BYTE_ZERO;
    end
  end

  // Architectural state leaves straight from its flops
  assign o_acc = acc_r;
  assign o_carry_flag = c_r;
  assign o_half_byte_borrow_flag = ac_r;
  assign o_zero_flag = z_r;
  assign o_signed_wrap_flag = ov_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_issue(rssk_op_e code);
    exec && (op == code);
  endsequence

  sequence s_skip_then_slot;
    o_skip_req ##0 (state_r == st_dummy);
  endsequence

  property p_rot_left_acc;
    s_issue(op_rotate_left_to_accum) |=> (acc_r == {$past(i_mem_data[6:0]),
      $past(i_mem_data[7])}) && !o_mem_we && $stable(flags_pack);
  endproperty
  a_rot_left_acc: assert property (p_rot_left_acc) else $error("left rotate wrong");

  property p_rot_left_mem;
    s_issue(op_rotate_left_thru_flag_in_mem) |=> o_mem_we
      && (o_mem_wdata == {$past(i_mem_data[6:0]), $past(c_r)}) && (c_r == $past(i_mem_data[7]));
  endproperty
  a_rot_left_mem: assert property (p_rot_left_mem) else $error("carry rotate wrong");

  property p_rot_right_acc;
    s_issue(op_rotate_right_thru_flag_to_accum) |=> !o_mem_we
      && (acc_r == {$past(c_r), $past(i_mem_data[7:1])}) && (c_r == $past(i_mem_data[0]));
  endproperty
  a_rot_right_acc: assert property (p_rot_right_acc) else $error("right rotate wrong");

  property p_sub_carry;
    s_issue(op_minus_mem_to_accum) |=> (c_r == ($past(acc_r) >= $past(i_mem_data)))
      && (acc_r == $past(acc_r) - $past(i_mem_data));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_dec_skip;
    s_issue(op_dec_skip_on_zero) ##0 (i_mem_data == BYTE_ONE) |=> o_skip_req && o_mem_we
      && (o_mem_wdata == BYTE_ZERO) ##1 (state_r == st_run);
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

  property p_dummy_noop;
    s_skip_then_slot |=> !o_mem_we && $stable(acc_r) && $stable(flags_pack) && !o_skip_req;
  endproperty
  a_dummy_noop: assert property (p_dummy_noop) else $error("skipped slot had effect");

  property p_bit_skip;
    s_issue(op_skip_if_bit_one) |=> (o_skip_req == $past(i_mem_data[i_bit_sel]))
      && !o_mem_we && $stable(flags_pack);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  property p_set_byte;
    s_issue(op_set_byte_in_mem) |=> o_mem_we && (o_mem_wdata == BYTE_ALL_ONES)
      && $stable(flags_pack);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("set byte wrong");

  property p_swap_acc;
    s_issue(op_nibble_exchange_to_accum) |=> !o_mem_we
      && (acc_r == {$past(i_mem_data[3:0]), $past(i_mem_data[7:4])});
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap wrong");

endmodule : rssk_exec_unit

`default_nettype wire

// ---- rssk_pkg.sv ----
// Purpose: Shared constants and types for the rotate, subtract and skip unit
// Assumes: 8-bit data path, one operation issued per cycle
// Notes: Operation codes are arbitrary encodings chosen for this block
`default_nettype none

package rssk_pkg;

  // Data width of the operand and accumulator
  localparam int DATA_W = 8;
  localparam int MSB_POS = 7;
  localparam int NIB_W = 4;

  // Operation codes presented by decode
  typedef enum logic [4:0] {
    op_nop                          = 5'h00,
    op_rotate_left_to_accum         = 5'h01,
    op_rotate_left_thru_flag_in_mem = 5'h02,
    op_rotate_left_thru_flag_to_accum = 5'h03,
    op_rotate_right_in_mem          = 5'h04,
    op_rotate_right_to_accum        = 5'h05,
    op_rotate_right_thru_flag_in_mem = 5'h06,
    op_rotate_right_thru_flag_to_accum = 5'h07,
    op_minus_with_borrow_to_accum   = 5'h08,
    op_minus_with_borrow_to_mem     = 5'h09,
    op_minus_mem_to_accum           = 5'h0a,
    op_minus_result_in_mem          = 5'h0b,
    op_minus_imm_to_accum           = 5'h0c,
    op_dec_skip_on_zero             = 5'h0d,
    op_dec_skip_on_zero_to_accum    = 5'h0e,
    op_inc_skip_on_zero             = 5'h0f,
    op_inc_skip_on_zero_to_accum    = 5'h10,
    op_skip_if_bit_one              = 5'h11,
    op_skip_if_mem_zero             = 5'h12,
    op_skip_if_zero_load_accum      = 5'h13,
    op_set_byte_in_mem              = 5'h14,
    op_set_bit_in_mem               = 5'h15,
    op_nibble_exchange_in_mem       = 5'h16,
    op_nibble_exchange_to_accum     = 5'h17
  } rssk_op_e;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    st_run   = 2'b01,
    st_dummy = 2'b10
  } rssk_state_e;

  // Register indices on the plain register port
  localparam logic [1:0] REG_ACC_IDX = 2'h0;
  localparam logic [1:0] REG_FLAGS_IDX = 2'h1;

  // Flag field positions in the flags register
  localparam int FLAG_C_POS = 0;
  localparam int FLAG_AC_POS = 1;
  localparam int FLAG_Z_POS = 2;
  localparam int FLAG_OV_POS = 3;
  localparam int FLAGS_W = 4;

  // Reset values and fixed byte values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

endpackage : rssk_pkg

`default_nettype wire

// ---- rssk_sub_unit.sv ----
// Purpose: Eight-bit subtractor with borrow input and status outputs
// Assumes: Carry and nibble flags mean no borrow when high
// Notes: Purely combinational, used by the execute unit
`default_nettype none

module rssk_sub_unit
  import rssk_pkg::*;
(
  input wire logic [DATA_W-1:0] i_minuend,
  input wire logic [DATA_W-1:0] i_subtrahend,
  input wire logic i_borrow_in,
  output logic [DATA_W-1:0] o_diff,
  output logic o_carry,
  output logic o_half,
  output logic o_zero,
  output logic o_wrap
);

  logic [DATA_W:0] full_diff;
  logic [NIB_W:0] nib_diff;

  // Ninth bit is the borrow out, so carry is its inverse
  assign full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {{DATA_W{1'b0}}, i_borrow_in};
  assign nib_diff = {1'b0, i_minuend[NIB_W-1:0]} - {1'b0, i_subtrahend[NIB_W-1:0]}
                  - {{NIB_W{1'b0}}, i_borrow_in};

  // Status outputs
  assign o_diff = full_diff[DATA_W-1:0];
  assign o_carry = ~full_diff[DATA_W];
  assign o_half = ~nib_diff[NIB_W];
  assign o_zero = (full_diff[DATA_W-1:0] == BYTE_ZERO);
  // Signed wrap when signs differ and result sign departs from minuend
  assign o_wrap = (i_minuend[MSB_POS] ^ i_subtrahend[MSB_POS])
                & (i_minuend[MSB_POS] ^ full_diff[MSB_POS]);

endmodule : rssk_sub_unit

`default_nettype wire
